// ==== rtl/camc_top.sv ====
// What this block does
// R1: Toggle enable inverts pin on each match
// R2: Toggle plus pulse width gives frequency output
// R3: Counter low byte readable, writable, holds LSBs
// R4: Five compare high bytes, read/write, reset zero
// R5: Match interrupt enable gates flag interrupt request
`timescale 1ns/1ns
`default_nettype none
module camc_top
  import camc_pkg::*;
#(
  parameter int ADR_W = 10 // Byte address width
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [CAMC_BUS_DW-1:0] wb_dat_i,
  output logic [CAMC_BUS_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic [CAMC_NUM-1:0] cex_o
);
  // Bus slave state
  logic ack_r; // Acknowledge register
  logic ack_nxt; // Next acknowledge
  logic [CAMC_BUS_DW-1:0] rd_r; // Read data register
  logic [CAMC_BUS_DW-1:0] rd_nxt; // Next read data
  camc_idx_t idx; // Register index from the address
  logic wr_go; // Write commits on this edge
  camc_byte_t wdat; // Low byte lane of write data

  // Counter state
  logic [15:0] cnt_r; // Array counter
  logic [15:0] cnt_nxt; // Next counter value
  logic cnt_new_r; // Counter advanced on the last edge
  logic cnt_new_nxt; // Next advance flag
  logic run_r; // Counter run enable
  logic run_nxt; // Next run enable

  // Per module registers
  camc_byte_t mode_r [CAMC_NUM]; // Mode control
  camc_byte_t mode_nxt [CAMC_NUM]; // Next mode control
  camc_byte_t cph_r [CAMC_NUM]; // Compare high byte
  camc_byte_t cph_nxt [CAMC_NUM]; // Next compare high byte
  camc_byte_t cpl_r [CAMC_NUM]; // Compare low byte
  camc_byte_t cpl_nxt [CAMC_NUM]; // Next compare low byte

  // Interrupt state
  logic [CAMC_NUM-1:0] flag_r; // Sticky capture/compare flags
  logic [CAMC_NUM-1:0] flag_nxt; // Next flags
  logic [CAMC_NUM-1:0] mask_r; // Interrupt mask
  logic [CAMC_NUM-1:0] mask_nxt; // Next mask
  logic [CAMC_NUM-1:0] irq_en; // Match interrupt enables
  logic [CAMC_NUM-1:0] match; // Match pulses from the units
  logic [CAMC_NUM-1:0] freq_mode; // Frequency output per module

  // True when a committing write targets the given index
  function automatic logic wr_hit(input camc_idx_t i, input camc_idx_t t,
                                  input logic go);
    wr_hit = go && (i == t);
  endfunction : wr_hit

  // Index decode and write commit at the acknowledging edge
  assign idx = wb_adr_i[9:2];
  assign wdat = wb_dat_i[7:0];
  assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_r & wb_sel_i[0];

  // One compare unit per module
  genvar g;
  generate
    for (g = 0; g < CAMC_NUM; g++) begin : g_unit
      camc_unit_if uif ();
      // Configuration from the registers
      assign uif.toggle_enable = mode_r[g][CAMC_MODE_TOG];
      assign uif.pulse_width_enable = mode_r[g][CAMC_MODE_PWM];
      assign uif.cnt = cnt_r;
      assign uif.cnt_new = cnt_new_r;
      assign uif.cmp = {cph_r[g], cpl_r[g]};
      // Results back to the core
      assign match[g] = uif.match;
      assign cex_o[g] = uif.pin;
      assign irq_en[g] = mode_r[g][CAMC_MODE_IRQ];
      assign freq_mode[g] = mode_r[g][CAMC_MODE_TOG]
                            & mode_r[g][CAMC_MODE_PWM];
      camc_unit u_unit (
        .sys_clk(sys_clk),
        .rst(rst),
        .u(uif.unit)
      );
    end
  endgenerate

  // Bus answer: acknowledge one cycle after the request, drop after
  always_comb begin
    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    rd_nxt = rd_r;
    if (ack_nxt) begin
      // Unmapped indices read zero
      rd_nxt = '0;
      if (idx == CAMC_IDX_CNT_LO) begin
        rd_nxt[7:0] = cnt_r[7:0]; // R3
      end
      if (idx == CAMC_IDX_CNT_HI) begin
        rd_nxt[7:0] = cnt_r[15:8];
      end
      if (idx == CAMC_IDX_CTRL) begin
        rd_nxt[CAMC_CTRL_RUN] = run_r;
      end
      if (idx == CAMC_IDX_STATUS) begin
        rd_nxt[CAMC_NUM-1:0] = flag_r;
      end
      if (idx == CAMC_IDX_MASK) begin
        rd_nxt[CAMC_NUM-1:0] = mask_r;
      end
      for (int n = 0; n < CAMC_NUM; n++) begin
        if (idx == CAMC_IDX_MODE[n]) begin
          rd_nxt[7:0] = mode_r[n];
        end
        if (idx == CAMC_IDX_CPH[n]) begin
          rd_nxt[7:0] = cph_r[n]; // R4
        end
        if (idx == CAMC_IDX_CPL[n]) begin
          rd_nxt[7:0] = cpl_r[n];
        end
      end
    end
  end

  // Bus registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      rd_r <= '0;
    end else begin
      ack_r <= ack_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rd_r;

  // Counter: runs when enabled, software writes override a byte
  always_comb begin
    run_nxt = run_r;
    cnt_nxt = cnt_r;
    cnt_new_nxt = run_r;
    if (run_r) begin
      cnt_nxt = cnt_r + 16'h0001;
    end
    if (wr_hit(idx, CAMC_IDX_CTRL, wr_go)) begin
      run_nxt = wdat[CAMC_CTRL_RUN];
    end
    if (wr_hit(idx, CAMC_IDX_CNT_LO, wr_go)) begin
      cnt_nxt[7:0] = wdat; // R3
      cnt_new_nxt = 1'b1;
    end
    if (wr_hit(idx, CAMC_IDX_CNT_HI, wr_go)) begin
      cnt_nxt[15:8] = wdat;
      cnt_new_nxt = 1'b1;
    end
  end

  // Counter registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      run_r <= 1'b0;
      cnt_r <= CAMC_RST_CNT;
      cnt_new_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
      cnt_r <= cnt_nxt;
      cnt_new_r <= cnt_new_nxt;
    end
  end

  // Module registers; frequency mode advances the low byte on match
  always_comb begin
    for (int n = 0; n < CAMC_NUM; n++) begin
      mode_nxt[n] = mode_r[n];
      cph_nxt[n] = cph_r[n];
      cpl_nxt[n] = cpl_r[n];
      // Next edge one half period later
      if (freq_mode[n] && match[n]) begin
        cpl_nxt[n] = cpl_r[n] + cph_r[n]; // R2
      end
      if (wr_hit(idx, CAMC_IDX_MODE[n], wr_go)) begin
        mode_nxt[n] = wdat;
      end
      if (wr_hit(idx, CAMC_IDX_CPH[n], wr_go)) begin
        cph_nxt[n] = wdat; // R4
      end
      // Software write wins over the advance
      if (wr_hit(idx, CAMC_IDX_CPL[n], wr_go)) begin
        cpl_nxt[n] = wdat;
      end
    end
  end

  // Module register bank
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (int n = 0; n < CAMC_NUM; n++) begin
        mode_r[n] <= CAMC_RST_BYTE;
        cph_r[n] <= CAMC_RST_BYTE; // R4
        cpl_r[n] <= CAMC_RST_BYTE;
      end
    end else begin
      for (int n = 0; n < CAMC_NUM; n++) begin
        mode_r[n] <= mode_nxt[n];
        cph_r[n] <= cph_nxt[n];
        cpl_r[n] <= cpl_nxt[n];
      end
    end
  end

  // Flags: write one clears, a match in the same cycle wins
  always_comb begin
    flag_nxt = flag_r;
    mask_nxt = mask_r;
    if (wr_hit(idx, CAMC_IDX_STATUS, wr_go)) begin
      flag_nxt = flag_r & ~wdat[CAMC_NUM-1:0];
    end
    if (wr_hit(idx, CAMC_IDX_MASK, wr_go)) begin
      mask_nxt = wdat[CAMC_NUM-1:0];
    end
    flag_nxt = flag_nxt | match; // R5
  end

  // Flag and mask registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      flag_r <= '0;
      mask_r <= '0;
    end else begin
      flag_r <= flag_nxt;
      mask_r <= mask_nxt;
    end
  end

  // Request needs flag, mask and the module's interrupt enable
  assign irq_o = |(flag_r & mask_r & irq_en); // R5

  // Acknowledge follows a fresh request by one cycle
  a_ack_one_cycle: assert property (
    @(posedge sys_clk) disable iff (rst)
    (wb_cyc_i && wb_stb_i && !ack_r) |=> ack_r)
    else $error("acknowledge late");

  // Acknowledge never lasts two cycles
  a_ack_single: assert property (
    @(posedge sys_clk) disable iff (rst)
    ack_r |=> !ack_r)
    else $error("acknowledge held");

  // Counter low byte takes written data
  a_cnt_low_write: assert property ( // R3
    @(posedge sys_clk) disable iff (rst)
    wr_hit(idx, CAMC_IDX_CNT_LO, wr_go)
    |=> (cnt_r[7:0] == $past(wb_dat_i[7:0])))
    else $error("counter low byte write lost");

  // Counter low byte reads back what counts
  a_cnt_low_read: assert property ( // R3
    @(posedge sys_clk) disable iff (rst)
    (ack_nxt && idx == CAMC_IDX_CNT_LO)
    |=> (wb_dat_o[7:0] == $past(cnt_r[7:0])))
    else $error("counter low byte read wrong");

  // Compare high byte of module four takes written data
  a_cph_write: assert property ( // R4
    @(posedge sys_clk) disable iff (rst)
    wr_hit(idx, CAMC_IDX_CPH[4], wr_go)
    |=> (cph_r[4] == $past(wb_dat_i[7:0])))
    else $error("compare high byte write lost");

  // Frequency mode advances the low compare byte
  a_freq_advance: assert property ( // R2
    @(posedge sys_clk) disable iff (rst)
    (freq_mode[1] && match[1] && !wr_hit(idx, CAMC_IDX_CPL[1], wr_go))
    |=> (cpl_r[1] == 8'($past(cpl_r[1]) + $past(cph_r[1]))))
    else $error("frequency compare not advanced");

  // A match always leaves its flag set
  a_flag_on_match: assert property ( // R5
    @(posedge sys_clk) disable iff (rst)
    (|match) |=> ((flag_r & $past(match)) == $past(match)))
    else $error("match flag lost");

  // No request without an enabled, set flag
  a_irq_enable: assert property ( // R5
    @(posedge sys_clk) disable iff (rst)
    irq_o |-> |(flag_r & irq_en))
    else $error("interrupt without enable");

  // Enabled unmasked match raises the request next cycle
  a_irq_raise: assert property ( // R5
    @(posedge sys_clk) disable iff (rst)
    (match[0] && irq_en[0] && mask_r[0] && $stable(mode_r[0])
     && !wr_go) |=> irq_o)
    else $error("interrupt not raised");

  c_bus_write: cover property (
    @(posedge sys_clk) disable iff (rst) wr_go);
  c_irq_seen: cover property (
    @(posedge sys_clk) disable iff (rst) $rose(irq_o));
  c_flag_clear_race: cover property (
    @(posedge sys_clk) disable iff (rst)
    (|match) && wr_hit(idx, CAMC_IDX_STATUS, wr_go));
endmodule : camc_top
`default_nettype wire

// ==== rtl/camc_pkg.sv ====
package camc_pkg;
  // Number of capture/compare modules in the array
  localparam int CAMC_NUM = 5;
  // Register data width and bus data width
  localparam int CAMC_DW = 8;
  localparam int CAMC_BUS_DW = 32;
  // Register index type; byte address is four times the index
  typedef logic [7:0] camc_idx_t;
  // One register byte
  typedef logic [7:0] camc_byte_t;
  // Mode control registers, one per module
  localparam camc_idx_t CAMC_IDX_MODE [0:4] =
    '{8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDE};
  // Compare high byte registers, one per module
  localparam camc_idx_t CAMC_IDX_CPH [0:4] =
    '{8'hFC, 8'hEA, 8'hEC, 8'hEE, 8'hFE};
  // Compare low byte registers, one per module
  localparam camc_idx_t CAMC_IDX_CPL [0:4] =
    '{8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5};
  // Counter bytes
  localparam camc_idx_t CAMC_IDX_CNT_LO = 8'hF9;
  localparam camc_idx_t CAMC_IDX_CNT_HI = 8'hC0;
  // Run control, sticky flags and interrupt mask
  localparam camc_idx_t CAMC_IDX_CTRL = 8'hC8;
  localparam camc_idx_t CAMC_IDX_STATUS = 8'hC9;
  localparam camc_idx_t CAMC_IDX_MASK = 8'hCA;
  // Field positions in a mode control register
  localparam int CAMC_MODE_TOG = 2;
  localparam int CAMC_MODE_PWM = 1;
  localparam int CAMC_MODE_IRQ = 0;
  // Field position of the run bit in the control register
  localparam int CAMC_CTRL_RUN = 0;
  // Reset values
  localparam camc_byte_t CAMC_RST_BYTE = 8'h00;
  localparam logic [15:0] CAMC_RST_CNT = 16'h0000;
endpackage : camc_pkg

// ==== rtl/camc_unit_if.sv ====
`timescale 1ns/1ns
`default_nettype none
// Signals between the register core and one compare module
interface camc_unit_if;
  logic toggle_enable; // Toggle on match
  logic pulse_width_enable; // Pulse width output
  logic [15:0] cnt; // Array counter value
  logic cnt_new; // Counter advanced on the last edge
  logic [15:0] cmp; // Compare value, high and low byte
  logic match; // One-cycle match pulse
  logic pin; // Registered pin level
  // Core side drives configuration, reads results
  modport core (
    output toggle_enable, pulse_width_enable, cnt, cnt_new, cmp,
    input match, pin
  );
  // Unit side reads configuration, drives results
  modport unit (
    input toggle_enable, pulse_width_enable, cnt, cnt_new, cmp,
    output match, pin
  );
endinterface : camc_unit_if
`default_nettype wire

// ==== rtl/camc_unit.sv ====
`timescale 1ns/1ns
`default_nettype none
// One compare module: match detection and pin waveform
module camc_unit
  import camc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  camc_unit_if.unit u
);
  logic pin_r; // Pin level register
  logic pin_nxt; // Next pin level
  logic eq_full; // Full 16-bit equality
  logic eq_low; // Low byte equality
  logic freq_mode; // Both enables set

  // Match only when the counter has just taken a new value
  always_comb begin
    freq_mode = u.toggle_enable & u.pulse_width_enable; // R2
    eq_full = (u.cnt == u.cmp);
    eq_low = (u.cnt[7:0] == u.cmp[7:0]);
    // Frequency and pulse modes compare the low byte only
    if (u.pulse_width_enable) begin
      u.match = u.cnt_new & eq_low;
    end else begin
      u.match = u.cnt_new & eq_full;
    end
  end

  // Next pin level per mode
  always_comb begin
    pin_nxt = pin_r;
    if (freq_mode) begin
      // Square wave: invert on every low byte match
      if (u.match) begin
        pin_nxt = ~pin_r; // R2
      end
    end else if (u.toggle_enable) begin
      // Plain toggle on full match
      if (u.match) begin
        pin_nxt = ~pin_r; // R1
      end
    end else if (u.pulse_width_enable) begin
      // High until the low byte reaches the compare value
      pin_nxt = (u.cnt[7:0] < u.cmp[7:0]);
    end
  end

  // Pin register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  assign u.pin = pin_r;

  // Toggle mode inverts on a match
  a_toggle_inverts: assert property ( // R1
    @(posedge sys_clk) disable iff (rst)
    (u.toggle_enable && !u.pulse_width_enable && u.match)
    |=> (pin_r == !$past(pin_r)))
    else $error("toggle mode missed a match");

  // Without either enable the pin holds
  a_no_toggle_hold: assert property ( // R1
    @(posedge sys_clk) disable iff (rst)
    (!u.toggle_enable && !u.pulse_width_enable) |=> $stable(pin_r))
    else $error("pin moved with toggle disabled");

  // Frequency mode inverts on a low byte match
  a_freq_inverts: assert property ( // R2
    @(posedge sys_clk) disable iff (rst)
    (u.toggle_enable && u.pulse_width_enable && u.cnt_new
     && u.cnt[7:0] == u.cmp[7:0]) |=> $changed(pin_r))
    else $error("frequency mode missed a match");

  c_freq_toggle: cover property (
    @(posedge sys_clk) disable iff (rst)
    (u.toggle_enable && u.pulse_width_enable && u.match));
endmodule : camc_unit
`default_nettype wire

// ==== sim/test_camc_top.sv ====
`timescale 1ns/1ns
`default_nettype none
// Register-level bench for the compare module block
module test_camc_top
  import camc_pkg::*;
;
  logic sys_clk = 1'b0; // Bus clock
  logic rst = 1'b1; // Async reset, held at start
  logic wb_cyc_i = 1'b0; // Bus cycle
  logic wb_stb_i = 1'b0; // Bus strobe
  logic wb_we_i = 1'b0; // Write select
  logic [9:0] wb_adr_i = 10'h000; // Byte address
  logic [3:0] wb_sel_i = 4'h0; // Byte enables
  logic [CAMC_BUS_DW-1:0] wb_dat_i = 32'h00000000; // Write data
  logic [CAMC_BUS_DW-1:0] wb_dat_o; // Read data
  logic wb_ack_o; // Acknowledge
  logic irq_o; // Interrupt level
  logic [CAMC_NUM-1:0] cex_o; // Module pins
  int err_count = 0; // Mismatches seen
  int checks_done = 0; // Comparisons made
  camc_byte_t rdv; // Last read byte

  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;

  camc_top #(.ADR_W(10)) uut (
    .sys_clk(sys_clk),
    .rst(rst),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .irq_o(irq_o),
    .cex_o(cex_o)
  );

  // Prints counts and verdict, ends the run
  task wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // Compares one value against its expectation
  task chk(input string name, input logic [7:0] seen,
           input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One classic bus cycle, held until ack is sampled high
  task automatic bus(input logic we, input camc_idx_t idx,
                     input camc_byte_t wd, input logic [3:0] sel,
                     output camc_byte_t rd);
    int n;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_sel_i <= sel;
    wb_dat_i <= {24'h000000, wd};
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    // A slave that never answers ends the run
    if (n >= 50) begin
      err_count++;
      $display("BAD ack wait expected 1 seen timeout");
      wrap_up();
    end
  endtask : bus

  // Full-byte register write
  task wr(input camc_idx_t idx, input camc_byte_t d);
    bus(1'b1, idx, d, 4'hF, rdv);
  endtask : wr

  // Register read and compare
  task rd_chk(input string name, input camc_idx_t idx,
              input camc_byte_t exp);
    bus(1'b0, idx, 8'h00, 4'hF, rdv);
    chk(name, rdv, exp);
  endtask : rd_chk

  // Lets match, flag and pin updates land
  task settle;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : settle

  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values, then distinct patterns per module
    for (int i = 0; i < CAMC_NUM; i++) begin
      rd_chk("cph reset", CAMC_IDX_CPH[i], 8'h00);
      wr(CAMC_IDX_CPH[i], 8'(8'h3C + 8'h11 * i));
    end
    for (int i = 0; i < CAMC_NUM; i++) begin
      rd_chk("cph rw", CAMC_IDX_CPH[i], 8'(8'h3C + 8'h11 * i));
    end
    // Write without low byte enable is dropped
    bus(1'b1, CAMC_IDX_CPH[2], 8'hAA, 4'hE, rdv);
    rd_chk("cph sel", CAMC_IDX_CPH[2], 8'h5E);
    rd_chk("unmapped", 8'h00, 8'h00);
    // Counter low byte, untouched by a high byte write
    wr(CAMC_IDX_CNT_LO, 8'h5A);
    rd_chk("cnt lo", CAMC_IDX_CNT_LO, 8'h5A);
    wr(CAMC_IDX_CNT_HI, 8'hA5);
    rd_chk("cnt lo keep", CAMC_IDX_CNT_LO, 8'h5A);
    // Toggle on full match, module 0
    wr(CAMC_IDX_CPH[0], 8'h00);
    wr(CAMC_IDX_CPL[0], 8'h10);
    wr(CAMC_IDX_CNT_HI, 8'h00);
    wr(CAMC_IDX_MODE[0], 8'h04);
    wr(CAMC_IDX_CNT_LO, 8'h10);
    settle();
    chk("pin0 set", {7'h00, cex_o[0]}, 8'h01);
    wr(CAMC_IDX_CNT_LO, 8'h10);
    settle();
    chk("pin0 back", {7'h00, cex_o[0]}, 8'h00);
    wr(CAMC_IDX_MODE[0], 8'h00);
    wr(CAMC_IDX_CNT_LO, 8'h10);
    settle();
    chk("pin0 off", {7'h00, cex_o[0]}, 8'h00);
    // Frequency output, module 1: low byte match, step by high byte
    wr(CAMC_IDX_CPH[1], 8'h20);
    wr(CAMC_IDX_CPL[1], 8'h30);
    wr(CAMC_IDX_CNT_HI, 8'h77);
    wr(CAMC_IDX_MODE[1], 8'h06);
    wr(CAMC_IDX_CNT_LO, 8'h30);
    settle();
    chk("pin1 set", {7'h00, cex_o[1]}, 8'h01);
    rd_chk("cpl1 step", CAMC_IDX_CPL[1], 8'h50);
    wr(CAMC_IDX_CNT_LO, 8'h30);
    settle();
    chk("pin1 hold", {7'h00, cex_o[1]}, 8'h01);
    wr(CAMC_IDX_CNT_LO, 8'h50);
    settle();
    chk("pin1 back", {7'h00, cex_o[1]}, 8'h00);
    // Pulse width only, module 2: pin high while low byte is below
    wr(CAMC_IDX_CPL[2], 8'h40);
    wr(CAMC_IDX_MODE[2], 8'h02);
    wr(CAMC_IDX_CNT_LO, 8'h20);
    settle();
    chk("pin2 below", {7'h00, cex_o[2]}, 8'h01);
    wr(CAMC_IDX_CNT_LO, 8'h60);
    settle();
    chk("pin2 above", {7'h00, cex_o[2]}, 8'h00);
    chk("pins idle", {6'h00, cex_o[4:3]}, 8'h00);
    // Flag, mask and per-module enable gate the interrupt
    wr(CAMC_IDX_STATUS, 8'h1F);
    rd_chk("flags clr", CAMC_IDX_STATUS, 8'h00);
    wr(CAMC_IDX_CNT_HI, 8'h00);
    wr(CAMC_IDX_CNT_LO, 8'h10);
    settle();
    rd_chk("flag0", CAMC_IDX_STATUS, 8'h01);
    chk("irq masked", {7'h00, irq_o}, 8'h00);
    wr(CAMC_IDX_MASK, 8'h01);
    settle();
    chk("irq no enable", {7'h00, irq_o}, 8'h00);
    wr(CAMC_IDX_MODE[0], 8'h01);
    settle();
    chk("irq on", {7'h00, irq_o}, 8'h01);
    wr(CAMC_IDX_MODE[0], 8'h00);
    settle();
    chk("irq disabled", {7'h00, irq_o}, 8'h00);
    wr(CAMC_IDX_MODE[0], 8'h01);
    wr(CAMC_IDX_STATUS, 8'h01);
    settle();
    chk("irq cleared", {7'h00, irq_o}, 8'h00);
    // Enabled, unmasked match raises the request
    wr(CAMC_IDX_CNT_LO, 8'h10);
    settle();
    chk("irq on match", {7'h00, irq_o}, 8'h01);
    // Running counter: first read sees one increment after run
    wr(CAMC_IDX_CNT_LO, 8'h80);
    wr(CAMC_IDX_CTRL, 8'h01);
    rd_chk("cnt lo run", CAMC_IDX_CNT_LO, 8'h81);
    rd_chk("ctrl run", CAMC_IDX_CTRL, 8'h01);
    wrap_up();
  end
endmodule : test_camc_top
`default_nettype wire
